/* File: pileup_counting_defs.vh */
// constants for pulse pile-up rejection and counting logic
`ifndef PILEUP_COUNTING_DEFS_VH
`define PILEUP_COUNTING_DEFS_VH

// data path widths
`define SAMPLE_W        16
`define PEAK_TIME_W     12
`define WINDOW_W        14
`define RISE_W          12
`define RESET_PER_W     16
`define XFER_PER_W      24
`define COUNT_W         32

// sample clock and fast channel dead time
`define CLK_PERIOD_NS   100
`define FAST_DEAD_NS    400
`define FAST_DEAD_CYC   ((`FAST_DEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_W          4

// pile-up window is peaking time plus 3/16 of it
`define PUR_FRAC_NUM    3
`define PUR_FRAC_SHIFT  4

// slow channel pulse tracker states
`define ST_IDLE         1'b0
`define ST_PULSE        1'b1

`endif

/* File: pulse_pileup_counting.v */
// pulse selection, pile-up rejection, counters and acquisition timer
`include "pileup_counting_defs.vh"
`default_nettype none

// Operation
// - one new shaped sample is taken on every sample clock edge.
// - peak is tracked live every sample, no conversion pause or dead time.
// - fast events closer than 400 ns increment the fast counter only once.
// - fast dead interval restarts on every detected event, counted or not.
// - pile-up window lasts peaking time plus three sixteenths of it.
// - with rejection on, overlapping pulses resolved by the fast channel are both discarded from spectrum and slow count.
// - pulses farther apart than 19/16 peaking time are both binned and counted.
// - rejection on, 400 ns to 19/16 peaking: no bin or slow count, two fast.
// - rejection off, 400 ns to peaking time: one combined bin, two fast counts.
// - closer than 400 ns: one bin, one slow count and one fast count.
// - fast and slow channels each use their own programmable threshold.
// - fast detections above fast threshold drive the pile-up rejection circuit.
// - pile-up rejection and risetime discrimination gate recording, each switchable off.
// - acquisition timer stops during serial transfers and preamplifier reset intervals.
// - configured reset period inhibits acquisition and halts timer after each reset.
// - fast count, slow count and acquisition time are reported to the controller.
// - approximate interval timer triggers reports; measured acquisition time accompanies counts.
module pulse_pileup_counting (
  // clock and reset
  input  wire                        i_core_clk,
  input  wire                        i_rstn,
  // shaped samples from the pipeline, one per clock
  input  wire [`SAMPLE_W-1:0]        i_fast_sample,
  input  wire [`SAMPLE_W-1:0]        i_slow_sample,
  // configuration
  input  wire [`SAMPLE_W-1:0]        i_fast_threshold,
  input  wire [`SAMPLE_W-1:0]        i_slow_threshold,
  input  wire [`PEAK_TIME_W-1:0]     i_peaking_time,
  input  wire                        i_pileup_reject_enable,
  input  wire                        i_risetime_discriminate_enable,
  input  wire [`RISE_W-1:0]          i_risetime_max,
  input  wire [`RESET_PER_W-1:0]     i_reset_period,
  input  wire [`XFER_PER_W-1:0]      i_transfer_period,
  // asynchronous status pins
  input  wire                        i_serial_busy,
  input  wire                        i_preamp_reset,
  // spectrum output
  output reg                         o_peak_valid,
  output reg  [`SAMPLE_W-1:0]        o_peak_value,
  // reported results
  output reg                         o_result_valid,
  output reg  [`COUNT_W-1:0]         o_fast_count,
  output reg  [`COUNT_W-1:0]         o_slow_count,
  output reg  [`COUNT_W-1:0]         o_acq_time,
  output reg                         o_acq_inhibit
);

  // integer forms are cut to the counter widths on purpose
  localparam integer          DEAD_CYC_I = `FAST_DEAD_CYC;
  localparam integer          FRAC_NUM_I = `PUR_FRAC_NUM;
  localparam [`DEAD_W-1:0]    DEAD_CYC   = DEAD_CYC_I[`DEAD_W-1:0];
  localparam [`WINDOW_W-1:0]  FRAC_NUM   = FRAC_NUM_I[`WINDOW_W-1:0];

  // pin synchronisers
  reg                       busy_meta_ff;
  reg                       busy_ff;
  reg                       prst_meta_ff;
  reg                       prst_ff;

  // fast channel
  reg                       fast_above_d_ff;
  reg [`DEAD_W-1:0]         dead_cnt_ff;
  reg [`WINDOW_W-1:0]       pur_cnt_ff;
  reg                       pile_hold_ff;

  // slow channel
  reg                       state_ff;
  reg [`SAMPLE_W-1:0]       peak_ff;
  reg [`RISE_W-1:0]         elapsed_ff;
  reg [`RISE_W-1:0]         rise_ff;
  reg                       piled_ff;

  // acquisition control
  reg [`RESET_PER_W-1:0]    inhibit_cnt_ff;
  reg [`XFER_PER_W-1:0]     xfer_cnt_ff;
  reg [`COUNT_W-1:0]        fast_cnt_ff;
  reg [`COUNT_W-1:0]        slow_cnt_ff;
  reg [`COUNT_W-1:0]        acq_cnt_ff;

  wire                      fast_above;
  wire                      fast_evt;
  wire                      fast_live;
  wire                      fast_counted;
  wire                      pile_evt;
  wire [`WINDOW_W-1:0]      pt_ext;
  wire [`WINDOW_W-1:0]      pur_window;
  wire                      slow_above;
  wire                      pulse_end;
  wire                      rise_bad;
  wire                      pile_bad;
  wire                      accept;
  wire                      inhibit;
  wire                      xfer;
  wire                      acq_run;
  wire [`COUNT_W-1:0]       fast_inc;
  wire [`COUNT_W-1:0]       slow_inc;
  wire [`COUNT_W-1:0]       acq_inc;

  // pins come from outside the clock domain
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_meta_ff <= 1'b0;
      busy_ff      <= 1'b0;
      prst_meta_ff <= 1'b0;
      prst_ff      <= 1'b0;
    end else begin
      busy_meta_ff <= i_serial_busy;
      busy_ff      <= busy_meta_ff;
      prst_meta_ff <= i_preamp_reset;
      prst_ff      <= prst_meta_ff;
    end
  end

  // fast channel trigger on its own threshold
  assign fast_above = (i_fast_sample > i_fast_threshold);
  assign fast_evt   = fast_above & ~fast_above_d_ff;
  // only events outside the dead interval are resolved as separate pulses
  assign fast_live  = fast_evt & (dead_cnt_ff == {`DEAD_W{1'b0}});
  assign fast_counted = fast_live & ~inhibit;

  // window = peaking time * (1 + 3/16); the product stays below 2^14
  assign pt_ext     = {{(`WINDOW_W-`PEAK_TIME_W){1'b0}}, i_peaking_time};
  assign pur_window = pt_ext + ((pt_ext * FRAC_NUM) >> `PUR_FRAC_SHIFT);
  // a second resolved fast trigger while the window is open means pile-up;
  // one inside the dead time is the same pulse as far as the fast channel can tell
  assign pile_evt   = fast_live & (pur_cnt_ff != {`WINDOW_W{1'b0}});

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fast_above_d_ff <= 1'b0;
      dead_cnt_ff     <= {`DEAD_W{1'b0}};
      pur_cnt_ff      <= {`WINDOW_W{1'b0}};
      pile_hold_ff    <= 1'b0;
    end else begin
      fast_above_d_ff <= fast_above;
      // paralyzable: every event restarts the dead interval
      if (fast_evt) begin
        dead_cnt_ff <= DEAD_CYC;
      end else if (dead_cnt_ff != {`DEAD_W{1'b0}}) begin
        dead_cnt_ff <= dead_cnt_ff - 1'b1;
      end
      if (fast_evt) begin
        pur_cnt_ff <= pur_window;
      end else if (pur_cnt_ff != {`WINDOW_W{1'b0}}) begin
        pur_cnt_ff <= pur_cnt_ff - 1'b1;
      end
      // remember the pile-up until the window fully closes
      if (pile_evt) begin
        pile_hold_ff <= 1'b1;
      end else if (pur_cnt_ff == {`WINDOW_W{1'b0}}) begin
        pile_hold_ff <= 1'b0;
      end
    end
  end

  // slow channel on its own threshold
  assign slow_above = (i_slow_sample > i_slow_threshold);
  assign pulse_end  = (state_ff == `ST_PULSE) & ~slow_above;
  assign rise_bad   = i_risetime_discriminate_enable & (rise_ff > i_risetime_max);
  // both members of an overlapping pair resolved by the fast channel see the held pile-up mark
  assign pile_bad   = i_pileup_reject_enable & (piled_ff | pile_evt | pile_hold_ff);
  // one shaped pulse yields at most one bin and one slow count
  assign accept     = pulse_end & ~rise_bad & ~pile_bad & ~inhibit;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff   <= `ST_IDLE;
      peak_ff    <= {`SAMPLE_W{1'b0}};
      elapsed_ff <= {`RISE_W{1'b0}};
      rise_ff    <= {`RISE_W{1'b0}};
      piled_ff   <= 1'b0;
    end else begin
      case (state_ff)
        `ST_IDLE: begin
          if (slow_above) begin
            state_ff   <= `ST_PULSE;
            peak_ff    <= i_slow_sample;
            elapsed_ff <= {`RISE_W{1'b0}};
            rise_ff    <= {`RISE_W{1'b0}};
            piled_ff   <= pile_evt | pile_hold_ff;
          end
        end
        `ST_PULSE: begin
          if (!slow_above) begin
            state_ff <= `ST_IDLE;
          end else begin
            // saturating elapsed count, no wrap on very long pulses
            if (elapsed_ff != {`RISE_W{1'b1}}) begin
              elapsed_ff <= elapsed_ff + 1'b1;
            end
            // peak follows the samples with no pause
            if (i_slow_sample > peak_ff) begin
              peak_ff <= i_slow_sample;
              rise_ff <= elapsed_ff + 1'b1;
            end
            if (pile_evt) begin
              piled_ff <= 1'b1;
            end
          end
        end
        default: begin
          state_ff <= `ST_IDLE;
        end
      endcase
    end
  end

  // spectrum handoff
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_peak_valid <= 1'b0;
      o_peak_value <= {`SAMPLE_W{1'b0}};
    end else begin
      o_peak_valid <= accept;
      if (accept) begin
        o_peak_value <= peak_ff;
      end
    end
  end

  // reset period inhibit follows the end of each detector reset
  assign inhibit = prst_ff | (inhibit_cnt_ff != {`RESET_PER_W{1'b0}});
  // limitation: a pulse under way when the inhibit ends is judged at its end only
  assign acq_run = ~busy_ff & ~inhibit;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      inhibit_cnt_ff <= {`RESET_PER_W{1'b0}};
      o_acq_inhibit  <= 1'b0;
    end else begin
      // reloaded while reset stands, so the inhibit has no gap as reset falls
      if (prst_ff) begin
        inhibit_cnt_ff <= i_reset_period;
      end else if (inhibit_cnt_ff != {`RESET_PER_W{1'b0}}) begin
        inhibit_cnt_ff <= inhibit_cnt_ff - 1'b1;
      end
      o_acq_inhibit <= inhibit;
    end
  end

  // approximate interval timer; a zero period still fires each cycle
  assign xfer = (xfer_cnt_ff == {`XFER_PER_W{1'b0}});

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      xfer_cnt_ff <= {`XFER_PER_W{1'b0}};
    end else if (xfer) begin
      xfer_cnt_ff <= (i_transfer_period == {`XFER_PER_W{1'b0}}) ?
                     {`XFER_PER_W{1'b0}} : i_transfer_period - 1'b1;
    end else begin
      xfer_cnt_ff <= xfer_cnt_ff - 1'b1;
    end
  end

  // one-bit events widened to the counter width
  assign fast_inc = {{(`COUNT_W-1){1'b0}}, fast_counted};
  assign slow_inc = {{(`COUNT_W-1){1'b0}}, accept};
  assign acq_inc  = {{(`COUNT_W-1){1'b0}}, acq_run};

  // counters restart from the current cycle's increment so none is lost
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fast_cnt_ff <= {`COUNT_W{1'b0}};
      slow_cnt_ff <= {`COUNT_W{1'b0}};
      acq_cnt_ff  <= {`COUNT_W{1'b0}};
    end else if (xfer) begin
      fast_cnt_ff <= fast_inc;
      slow_cnt_ff <= slow_inc;
      acq_cnt_ff  <= acq_inc;
    end else begin
      fast_cnt_ff <= fast_cnt_ff + fast_inc;
      slow_cnt_ff <= slow_cnt_ff + slow_inc;
      acq_cnt_ff  <= acq_cnt_ff + acq_inc;
    end
  end

  // all three results latched in the same cycle
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_result_valid <= 1'b0;
      o_fast_count   <= {`COUNT_W{1'b0}};
      o_slow_count   <= {`COUNT_W{1'b0}};
      o_acq_time     <= {`COUNT_W{1'b0}};
    end else begin
      o_result_valid <= xfer;
      if (xfer) begin
        o_fast_count <= fast_cnt_ff;
        o_slow_count <= slow_cnt_ff;
        o_acq_time   <= acq_cnt_ff;
      end
    end
  end

endmodule // pulse_pileup_counting

`default_nettype wire

/* File: pileup_props.sv */
// assertion checker for the pulse pile-up counting block
`include "pileup_counting_defs.vh"
`default_nettype none
module pileup_props (
  // clock and reset
  input wire logic                    i_core_clk,
  input wire logic                    i_rstn,
  // watched pins
  input wire logic                    i_preamp_reset,
  input wire logic [`RESET_PER_W-1:0] i_reset_period,
  input wire logic [`XFER_PER_W-1:0]  i_transfer_period,
  input wire logic                    o_peak_valid,
  input wire logic [`SAMPLE_W-1:0]    o_peak_value,
  input wire logic                    o_result_valid,
  input wire logic [`COUNT_W-1:0]     o_fast_count,
  input wire logic [`COUNT_W-1:0]     o_slow_count,
  input wire logic [`COUNT_W-1:0]     o_acq_time,
  input wire logic                    o_acq_inhibit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // margin of 5 covers the pin synchroniser and output register
  logic [15:0] low_cnt_ff;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) low_cnt_ff <= 16'h0;
    else if (i_preamp_reset) low_cnt_ff <= 16'h0;
    else if (low_cnt_ff != 16'hffff) low_cnt_ff <= low_cnt_ff + 16'h1;
  end
  property p_result_gap;
    o_result_valid && i_transfer_period > 24'h8 |=> !o_result_valid [*8];
  endproperty
  a_result_gap: assert property (p_result_gap) else $error("result valid too close");
  property p_peak_pulse;
    o_peak_valid |=> !o_peak_valid;
  endproperty
  a_peak_pulse: assert property (p_peak_pulse) else $error("peak valid too long");
  property p_peak_hold;
    !o_peak_valid |-> $stable(o_peak_value);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak value moved");
  property p_count_hold;
    !o_result_valid |-> $stable({o_fast_count, o_slow_count, o_acq_time});
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("results moved");
  property p_acq_bound;
    o_result_valid |-> o_acq_time <= {8'h0, i_transfer_period};
  endproperty
  a_acq_bound: assert property (p_acq_bound) else $error("acq time too long");
  property p_inh_on;
    i_preamp_reset [*4] |-> o_acq_inhibit;
  endproperty
  a_inh_on: assert property (p_inh_on) else $error("no inhibit in reset");
  property p_inh_after;
    i_reset_period > 16'h8 && i_preamp_reset ##1 !i_preamp_reset [*4] |-> o_acq_inhibit;
  endproperty
  a_inh_after: assert property (p_inh_after) else $error("inhibit ended early");
  property p_inh_off;
    low_cnt_ff > i_reset_period + 16'h5 |-> !o_acq_inhibit;
  endproperty
  a_inh_off: assert property (p_inh_off) else $error("inhibit stuck");
endmodule // pileup_props
bind pulse_pileup_counting pileup_props u_props (.i_core_clk, .i_rstn, .i_preamp_reset,
  .i_reset_period, .i_transfer_period, .o_peak_valid, .o_peak_value, .o_result_valid,
  .o_fast_count, .o_slow_count, .o_acq_time, .o_acq_inhibit);
`default_nettype wire

/* File: mcu_model.sv */
// controller model: reads each result, then may hold the serial link busy
`default_nettype none
module mcu_model #(
  parameter int BUSY_CYC = 50
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // results and upload control
  input  wire logic        i_result_valid,
  input  wire logic        i_upload_en,
  // serial link status and results read
  output wire logic        o_serial_busy,
  output var  logic [31:0] o_reads
);
  timeunit 1ns;
  timeprecision 1ns;
  int busy_cnt_ff;
  // moves off the sampling edge like any other pin
  always @(negedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_cnt_ff <= 0;
      o_reads     <= 32'h0;
    end else if (i_result_valid) begin
      o_reads     <= o_reads + 32'h1;
      busy_cnt_ff <= i_upload_en ? BUSY_CYC : 0;
    end else if (busy_cnt_ff != 0) begin
      busy_cnt_ff <= busy_cnt_ff - 1;
    end
  end
  assign o_serial_busy = (busy_cnt_ff != 0);
endmodule // mcu_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the pulse pile-up counting block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PT = 20;
  logic        i_core_clk;
  logic        i_rstn = 1'b0;
  logic        pileup_reject_enable = 1'b0;
  logic        risetime_discriminate_enable = 1'b0;
  logic        upl = 1'b0;
  logic        prst = 1'b0;
  logic        busy;
  logic [15:0] fs = 16'h0;
  logic [15:0] ss = 16'h0;
  logic [15:0] fthr = 16'h64;
  logic [11:0] rmax = 12'hfff;
  logic        o_peak_valid, o_result_valid, o_acq_inhibit;
  logic [15:0] o_peak_value;
  logic [31:0] o_fast_count, o_slow_count, o_acq_time;
  logic [15:0] pk [2];
  int          miscompares, num_checks, npk, cyc;
  pulse_pileup_counting u_dut (.i_core_clk, .i_rstn, .i_fast_sample(fs), .i_slow_sample(ss),
    .i_fast_threshold(fthr), .i_slow_threshold(16'h32), .i_peaking_time(12'h14),
    .i_pileup_reject_enable(pileup_reject_enable), .i_risetime_discriminate_enable(risetime_discriminate_enable), .i_risetime_max(rmax),
    .i_reset_period(16'h1e), .i_transfer_period(24'hc8), .i_serial_busy(busy),
    .i_preamp_reset(prst), .o_peak_valid, .o_peak_value, .o_result_valid, .o_fast_count,
    .o_slow_count, .o_acq_time, .o_acq_inhibit);
  mcu_model u_mcu (.i_core_clk, .i_rstn, .i_result_valid(o_result_valid), .i_upload_en(upl),
    .o_serial_busy(busy), .o_reads());
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_peak_valid === 1'b1) begin
      if (npk < 2) pk[npk] <= o_peak_value;
      npk <= npk + 1;
    end
    if (cyc == 10000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // waits for the next report, a new interval starts there
  task automatic sync();
    int n;
    n = 0;
    @(negedge i_core_clk);
    while (o_result_valid !== 1'b1 && n < 400) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 400) begin
      miscompares++;
      complete_run();
    end
  endtask
  // triangles of base twice the peaking time, as the shaper gives
  function automatic logic [15:0] shape(input int x);
    return (x >= 0 && x <= 2*PT) ? 16'(400 - 20*((x > PT) ? x - PT : PT - x)) : 16'h0;
  endfunction
  task automatic pulses(input int a, input int b, input int c, input logic [15:0] famp);
    for (int k = 0; k < 100; k++) begin
      fs = (k == a || k == b || k == c) ? famp : 16'h0;
      ss = shape(k - a) + shape(k - b);
      @(negedge i_core_clk);
    end
  endtask
  task automatic run(input int a, input int b, input int c);
    sync();
    npk = 0;
    pulses(a, b, c, 16'hc8);
    sync();
  endtask
  task automatic t_far();
    for (int p = 0; p < 2; p++) begin
      pileup_reject_enable = (p == 1);
      run(0, 50, 500);
      chk("fast", 32'h2, o_fast_count);
      chk("slow", 32'h2, o_slow_count);
      chk("peaks", 32'h2, npk);
      chk("peak", 32'h190, pk[1]);
      chk("acq", 32'hc8, o_acq_time);
    end
    $display("test far done");
  endtask
  task automatic t_mid();
    pileup_reject_enable = 1'b1;
    run(0, 10, 500);
    chk("fast", 32'h2, o_fast_count);
    chk("slow", 32'h0, o_slow_count);
    chk("peaks", 32'h0, npk);
    run(0, 22, 500);
    chk("slow", 32'h0, o_slow_count);
    pileup_reject_enable = 1'b0;
    run(0, 10, 500);
    chk("fast", 32'h2, o_fast_count);
    chk("slow", 32'h1, o_slow_count);
    chk("peaks", 32'h1, npk);
    chk("peak", 32'h258, pk[0]);
    $display("test mid done");
  endtask
  task automatic t_close();
    for (int p = 0; p < 2; p++) begin
      pileup_reject_enable = (p == 1);
      run(0, 2, 500);
      chk("fast", 32'h1, o_fast_count);
      chk("slow", 32'h1, o_slow_count);
      chk("peak", 32'h2f8, pk[0]);
    end
    pileup_reject_enable = 1'b0;
    run(0, 3, 6);
    chk("fast", 32'h1, o_fast_count);
    $display("test close done");
  endtask
  task automatic t_gate();
    pileup_reject_enable = 1'b1;
    fthr = 16'h3e8;
    run(0, 10, 500);
    chk("fast", 32'h0, o_fast_count);
    chk("slow", 32'h1, o_slow_count);
    fthr = 16'h64;
    pileup_reject_enable = 1'b0;
    risetime_discriminate_enable = 1'b1;
    rmax = 12'h5;
    run(0, 500, 500);
    chk("peaks", 32'h0, npk);
    rmax = 12'h3e8;
    run(0, 500, 500);
    chk("peaks", 32'h1, npk);
    risetime_discriminate_enable = 1'b0;
    $display("test gate done");
  endtask
  task automatic t_timer();
    sync();
    prst = 1'b1;
    repeat (10) @(negedge i_core_clk);
    chk("inhibit", 32'h1, o_acq_inhibit);
    prst = 1'b0;
    pulses(0, 500, 500, 16'hc8);
    sync();
    chk("fast", 32'h0, o_fast_count);
    chk("acq", 32'ha0, o_acq_time);
    upl = 1'b1;
    sync();
    sync();
    chk("acq", 32'h96, o_acq_time);
    chk("inhibit", 32'h0, o_acq_inhibit);
    $display("test timer done");
  endtask
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_rstn = 1'b1;
    t_far();
    t_mid();
    t_close();
    t_gate();
    t_timer();
    complete_run();
  end
endmodule // tb
`default_nettype wire
